/* File: design/ahbi_pkg.sv */
`default_nettype none
package ahbi_pkg;
    // ==========================================
    // bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int HALF_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int CNT_W = 6;
    localparam int IRQ_W = 8;
    localparam int INSTR_DEPTH = 8;
    localparam int CHAN_W = 3;
    // ==========================================
    // word indices (16-bit mode, addr_lines[4:1])
    localparam logic [3:0] IDX_INSTR_LAST = 4'h7;
    localparam logic [3:0] IDX_CONFIG = 4'h8;
    localparam logic [3:0] IDX_IRQ_EN = 4'h9;
    localparam logic [3:0] IDX_IRQ_STAT = 4'hA;
    localparam logic [3:0] IDX_FIFO = 4'hF;
    // ==========================================
    // config fields
    localparam int CFG_START_BIT = 0;
    localparam int CFG_TRIG_DIR_BIT = 7;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
    localparam int THR_LSB = 8;
    // ==========================================
    // interrupt sources
    localparam int IRQ_CONV_DONE = 0;
    localparam int IRQ_THRESHOLD = 1;
    localparam int IRQ_FIFO_FULL = 2;
    localparam int IRQ_EXT_EVENT = 3;
    // ==========================================
    // conversion timing
    localparam int CONV_CYCLES = 44;
    localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);
    typedef enum logic [1:0] {AHBI_IDLE, AHBI_HOLD, AHBI_CONV} ahbi_state_t;
endpackage
`default_nettype wire

/* File: design/ahbi_trig_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module ahbi_trig_sync
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_trig,
    output logic o_rise
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    // ==========================================
    // two-stage sync, edge taken after stage two only
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= i_trig;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end
    assign o_rise = sync_reg & ~prev_reg;
    chk_rise_single: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        o_rise |-> ($past(i_trig, 2) && !$past(i_trig, 3))) else $error("trigger edge not from pin");
endmodule
`default_nettype wire

/* File: design/ahbi_addr_latch.sv */
`timescale 1ns/1ns
`default_nettype none
module ahbi_addr_latch
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_ale,
    input wire logic [ahbi_pkg::ADDR_W-1:0] i_addr_lines,
    input wire logic i_cs_n,
    output logic [ahbi_pkg::ADDR_W-1:0] o_addr,
    output logic o_cs_n
);
    logic [ahbi_pkg::ADDR_W-1:0] addr_reg;
    logic cs_n_reg;
    // ==========================================
    // latch follows while ale high, holds while low
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            addr_reg <= '0;
            cs_n_reg <= 1'b1;
        end
        else if (i_ale)
        begin
            addr_reg <= i_addr_lines;
            cs_n_reg <= i_cs_n;
        end
    end
    // transparent while ale high; frozen copy otherwise
    assign o_addr = i_ale ? i_addr_lines : addr_reg;
    assign o_cs_n = i_ale ? i_cs_n : cs_n_reg;
    chk_addr_hold: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (!i_ale && $past(!i_ale)) |-> $stable(o_addr)) else $error("latched address moved");
endmodule
`default_nettype wire

/* File: design/ahbi_top.sv */
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - width select high: low byte only
// - drive data only while select and read low
// - take writes only while select and write low
// - select low freezes conversion progress
// - latch strobe high passes address; fall captures
// - latch strobe low holds address and select
// - trigger input edge holds, next clock starts
// - trigger output high during conversion
// - reset makes trigger pin an input
// - unmasked interrupt source drives interrupt low
// - status read clears all, releases interrupt (a source set in the read cycle stays set)
// - transfer request rises at fifo threshold
// - transfer request holds until fifo empty
// - channel pair from instruction memory
// - word address A4-A1, byte address A4-A0
module ahbi_top
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_ale,
    input wire logic i_bus_width_select,
    input wire logic [ahbi_pkg::ADDR_W-1:0] i_addr_lines,
    input wire logic [ahbi_pkg::DATA_W-1:0] i_bus_lines,
    output logic [ahbi_pkg::DATA_W-1:0] o_bus_lines,
    output logic [ahbi_pkg::DATA_W-1:0] o_bus_lines_oe_n,
    input wire logic i_trig,
    output logic o_trig,
    output logic o_trig_oe_n,
    output logic o_int_n,
    output logic o_transfer_request,
    input wire logic [ahbi_pkg::DATA_W-1:0] i_conv_result,
    output logic [ahbi_pkg::CHAN_W-1:0] o_chan_pos,
    output logic [ahbi_pkg::CHAN_W-1:0] o_chan_neg,
    output logic o_chan_diff,
    output logic o_track_hold
);
    logic [ahbi_pkg::ADDR_W-1:0] addr;
    logic cs_n;
    logic trig_rise;
    logic byte_mode;
    logic rd_act;
    logic wr_act;
    logic rd_prev_reg;
    logic wr_prev_reg;
    logic rd_start;
    logic wr_start;
    logic [3:0] widx;
    logic hi_byte;
    logic [15:0] config_reg;
    logic [15:0] irq_en_reg;
    logic [7:0] irq_stat_reg;
    logic [7:0] irq_set;
    logic [15:0] instr_mem [ahbi_pkg::INSTR_DEPTH];
    logic [15:0] fifo_mem [ahbi_pkg::FIFO_DEPTH];
    logic [4:0] wr_ptr_reg;
    logic [4:0] rd_ptr_reg;
    logic [5:0] count_reg;
    logic [2:0] pc_reg;
    logic [5:0] conv_cnt_reg;
    logic dreq_reg;
    logic [15:0] rdata_reg;
    logic [15:0] wdata;
    logic [15:0] word_rd;
    logic conv_done;
    logic push;
    logic pop;
    ahbi_pkg::ahbi_state_t state_reg;

    function automatic logic [15:0] merge_byte(input logic [15:0] old, input logic [7:0] b, input logic hi);
        merge_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction

    ahbi_addr_latch u_latch
    (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_ale(i_ale),
        .i_addr_lines(i_addr_lines),
        .i_cs_n(i_cs_n),
        .o_addr(addr),
        .o_cs_n(cs_n)
    );
    ahbi_trig_sync u_sync
    (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_trig(i_trig),
        .o_rise(trig_rise)
    );
    // ==========================================
    // access decode
    assign byte_mode = i_bus_width_select;
    assign rd_act = !cs_n && !i_rd_n;
    assign wr_act = !cs_n && !i_wr_n;
    assign widx = addr[4:1];
    assign hi_byte = byte_mode & addr[0];
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
        end
        else
        begin
            rd_prev_reg <= rd_act;
            wr_prev_reg <= wr_act;
        end
    end
    // one internal action per strobe, on the leading cycle
    assign rd_start = rd_act & ~rd_prev_reg;
    assign wr_start = wr_act & ~wr_prev_reg;
    assign wdata = byte_mode ? {8'h00, i_bus_lines[7:0]} : i_bus_lines;
    // ==========================================
    // register writes
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            config_reg <= ahbi_pkg::CFG_RESET;
            irq_en_reg <= ahbi_pkg::IRQ_EN_RESET;
        end
        else if (wr_start)
        begin
            if (widx == ahbi_pkg::IDX_CONFIG)
                config_reg <= byte_mode ? merge_byte(config_reg, wdata[7:0], hi_byte) : wdata;
            else if (widx == ahbi_pkg::IDX_IRQ_EN)
                irq_en_reg <= byte_mode ? merge_byte(irq_en_reg, wdata[7:0], hi_byte) : wdata;
        end
    end
    // instruction memory: plain storage, no reset
    always_ff @(posedge i_ref_clk)
    begin
        if (wr_start && widx <= ahbi_pkg::IDX_INSTR_LAST)
            instr_mem[widx[2:0]] <= byte_mode ? merge_byte(instr_mem[widx[2:0]], wdata[7:0], hi_byte) : wdata;
    end
    // ==========================================
    // channel selection: [2:0] pos, [5:3] neg, [6] differential
    assign o_chan_pos = instr_mem[pc_reg][2:0];
    assign o_chan_neg = instr_mem[pc_reg][5:3];
    assign o_chan_diff = instr_mem[pc_reg][6];
    // ==========================================
    // sequencer; select low stalls it, risking lost throughput
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_reg <= ahbi_pkg::AHBI_IDLE;
            conv_cnt_reg <= '0;
            pc_reg <= '0;
        end
        else if (cs_n)
        begin
            case (state_reg)
                ahbi_pkg::AHBI_IDLE:
                begin
                    if (!config_reg[ahbi_pkg::CFG_TRIG_DIR_BIT] && trig_rise)
                        state_reg <= ahbi_pkg::AHBI_HOLD;
                    else if (config_reg[ahbi_pkg::CFG_TRIG_DIR_BIT] && config_reg[ahbi_pkg::CFG_START_BIT])
                        state_reg <= ahbi_pkg::AHBI_HOLD;
                end
                ahbi_pkg::AHBI_HOLD:
                begin
                    state_reg <= ahbi_pkg::AHBI_CONV;
                    conv_cnt_reg <= '0;
                end
                ahbi_pkg::AHBI_CONV:
                begin
                    if (conv_cnt_reg == ahbi_pkg::CONV_LAST)
                    begin
                        state_reg <= ahbi_pkg::AHBI_IDLE;
                        pc_reg <= pc_reg + 3'd1;
                    end
                    else
                        conv_cnt_reg <= conv_cnt_reg + 6'd1;
                end
                default:
                    state_reg <= ahbi_pkg::AHBI_IDLE;
            endcase
        end
    end
    assign conv_done = cs_n && state_reg == ahbi_pkg::AHBI_CONV && conv_cnt_reg == ahbi_pkg::CONV_LAST;
    assign o_track_hold = state_reg != ahbi_pkg::AHBI_IDLE;
    // pin direction: oe_n low drives; reset leaves it an input
    assign o_trig_oe_n = ~config_reg[ahbi_pkg::CFG_TRIG_DIR_BIT];
    assign o_trig = state_reg == ahbi_pkg::AHBI_CONV;
    // ==========================================
    // result fifo
    assign push = conv_done && count_reg != 6'(ahbi_pkg::FIFO_DEPTH);
    assign pop = rd_start && widx == ahbi_pkg::IDX_FIFO && count_reg != 6'd0 && (!byte_mode || hi_byte);
    always_ff @(posedge i_ref_clk)
    begin
        if (push)
            fifo_mem[wr_ptr_reg] <= i_conv_result;
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + 5'(push);
            rd_ptr_reg <= rd_ptr_reg + 5'(pop);
            count_reg <= count_reg + 6'(push) - 6'(pop);
        end
    end
    // ==========================================
    // transfer request
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            dreq_reg <= 1'b0;
        else if (count_reg == 6'd0)
            dreq_reg <= 1'b0;
        else if (count_reg == irq_en_reg[ahbi_pkg::THR_LSB +: 6])
            dreq_reg <= 1'b1;
    end
    assign o_transfer_request = dreq_reg;
    chk_dreq_empty: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (count_reg == 6'd0) |=> !o_transfer_request) else $error("request high with empty fifo");
    chk_dreq_rise: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        $rose(o_transfer_request) |-> $past(count_reg) == $past(irq_en_reg[13:8])) else $error("request off threshold");
    // ==========================================
    // interrupts: set wins over read-clear
    assign irq_set = {4'h0, trig_rise, count_reg == 6'(ahbi_pkg::FIFO_DEPTH),
        dreq_reg, conv_done};
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            irq_stat_reg <= '0;
        else if (rd_start && widx == ahbi_pkg::IDX_IRQ_STAT)
            irq_stat_reg <= irq_set;
        else
            irq_stat_reg <= irq_stat_reg | irq_set;
    end
    assign o_int_n = ~|(irq_stat_reg & irq_en_reg[7:0]);
    chk_int_clear: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (rd_start && widx == ahbi_pkg::IDX_IRQ_STAT && irq_set == 8'h00) |=> o_int_n) else $error("int not released");
    chk_int_drive: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        ((|(irq_set & irq_en_reg[7:0])) && !(wr_start && widx == ahbi_pkg::IDX_IRQ_EN))
        |=> !o_int_n) else $error("unmasked source not signalled");
    // ==========================================
    // read path
    always_comb
    begin
        case (widx)
            ahbi_pkg::IDX_CONFIG: word_rd = config_reg;
            ahbi_pkg::IDX_IRQ_EN: word_rd = irq_en_reg;
            ahbi_pkg::IDX_IRQ_STAT: word_rd = {2'b00, count_reg, irq_stat_reg};
            ahbi_pkg::IDX_FIFO: word_rd = fifo_mem[rd_ptr_reg];
            default: word_rd = (widx <= ahbi_pkg::IDX_INSTR_LAST) ? instr_mem[widx[2:0]] : 16'h0000;
        endcase
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rdata_reg <= '0;
        else if (rd_start)
            rdata_reg <= byte_mode ? {8'h00, (hi_byte ? word_rd[15:8] : word_rd[7:0])} : word_rd;
    end
    assign o_bus_lines = rdata_reg;
    // upper lane never driven in byte mode
    assign o_bus_lines_oe_n = {{8{~rd_act | byte_mode}}, {8{~rd_act}}};
    chk_bus_idle: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        !(rd_act) |-> (o_bus_lines_oe_n == 16'hFFFF)) else $error("bus driven outside read");
    chk_byte_upper: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        byte_mode |-> (&o_bus_lines_oe_n[15:8])) else $error("upper lane driven in byte mode");
    chk_cs_freeze: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (!cs_n && state_reg == ahbi_pkg::AHBI_CONV) |=> $stable(conv_cnt_reg)) else $error("conversion moved");
    chk_trig_start: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (cs_n && state_reg == ahbi_pkg::AHBI_HOLD) |=> state_reg == ahbi_pkg::AHBI_CONV) else $error("no start");
    cov_conv: cover property (@(posedge i_ref_clk) conv_done);
    cov_dreq: cover property (@(posedge i_ref_clk) $rose(o_transfer_request));
    cov_int: cover property (@(posedge i_ref_clk) $fell(o_int_n));
    // ==========================================
    // extra guards on sequencer, lanes and drain
    chk_trig_hold: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (cs_n && state_reg == ahbi_pkg::AHBI_IDLE && !config_reg[ahbi_pkg::CFG_TRIG_DIR_BIT] && trig_rise)
        |=> (o_track_hold && state_reg == ahbi_pkg::AHBI_HOLD)) else $error("trigger edge not held");
    chk_byte_write: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (wr_start && byte_mode && !hi_byte && widx == ahbi_pkg::IDX_IRQ_EN)
        |=> (irq_en_reg[15:8] == $past(irq_en_reg[15:8]))) else $error("upper lane written in byte mode");
    // request falls two cycles after the last pop, not with it
    chk_fifo_drain: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (pop && !push && count_reg == 6'd1) |=> ##1 !o_transfer_request) else $error("request kept after drain");
    cov_freeze: cover property (@(posedge i_ref_clk) !cs_n && state_reg == ahbi_pkg::AHBI_CONV);
    cov_trig_out: cover property (@(posedge i_ref_clk) !o_trig_oe_n && o_trig);
endmodule
`default_nettype wire

/* File: dv/ahbi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ahbi_host_model
(
    input wire logic i_ref_clk,
    input wire logic [ahbi_pkg::DATA_W-1:0] i_rdata,
    input wire logic [ahbi_pkg::DATA_W-1:0] i_oe_n,
    output logic o_cs_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_ale,
    output logic [ahbi_pkg::ADDR_W-1:0] o_addr,
    output logic [ahbi_pkg::DATA_W-1:0] o_wdata
);
    // ==========================================
    // idle bus
    initial
    begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_ale = 1'b1;
        o_addr = 5'h1f;
        o_wdata = 16'h0000;
    end
    // ==========================================
    // one access, entered just after a rising edge
    task automatic access(input logic wr, input logic sel, input logic mux, input logic [4:0] a,
        input logic [15:0] d, output logic [15:0] q, output logic [15:0] oe);
        o_cs_n <= ~sel;
        o_addr <= a;
        if (mux)
        begin
            @(posedge i_ref_clk);
            o_ale <= 1'b0;
            @(posedge i_ref_clk);
            o_addr <= ~a;
        end
        o_rd_n <= wr;
        o_wr_n <= ~wr;
        o_wdata <= d;
        @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        // undriven lanes read inverted, so an idle lane cannot pass
        q = i_rdata ^ i_oe_n;
        oe = i_oe_n;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_ale <= 1'b1;
        o_addr <= ~a;
        // released lines flip so a stale value cannot pass
        o_wdata <= ~d;
        @(posedge i_ref_clk);
    endtask
    // select held low on purpose: stalls conversion
    task automatic hold_select(input int n);
        o_cs_n <= 1'b0;
        repeat (n) @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
        @(posedge i_ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_adc_host_bus_interface.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_adc_host_bus_interface;
    logic clk, arst_n, bw, trig, cs_n, rd_n, wr_n, ale;
    logic trig_o, trig_oe_n, int_n, req, diff, hold;
    logic [15:0] conv, wdata, rdata, oe_n;
    logic [4:0] addr;
    logic [2:0] pos, neg;
    int n_mismatch;
    int check_count;
    ahbi_top i_dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_ale(ale), .i_bus_width_select(bw), .i_addr_lines(addr), .i_bus_lines(wdata),
        .o_bus_lines(rdata), .o_bus_lines_oe_n(oe_n), .i_trig(trig), .o_trig(trig_o),
        .o_trig_oe_n(trig_oe_n), .o_int_n(int_n), .o_transfer_request(req), .i_conv_result(conv),
        .o_chan_pos(pos), .o_chan_neg(neg), .o_chan_diff(diff), .o_track_hold(hold));
    ahbi_host_model i_host (.i_ref_clk(clk), .i_rdata(rdata), .i_oe_n(oe_n), .o_cs_n(cs_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ale(ale), .o_addr(addr), .o_wdata(wdata));
    // ==========================================
    // helpers
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic sel = 1'b1);
        logic [15:0] q;
        logic [15:0] oe;
        i_host.access(1'b1, sel, 1'b0, a, d, q, oe);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e,
        input logic [15:0] eoe, input logic mux = 1'b0);
        logic [15:0] q;
        logic [15:0] oe;
        i_host.access(1'b0, 1'b1, mux, a, 16'h0000, q, oe);
        check(q & m, e);
        check(oe, eoe);
        check(oe_n, 16'hffff);
    endtask
    // bounded wait on the hold output or the trigger output
    task automatic wait_on(input logic trg, input logic v);
        int k;
        k = 0;
        while (((trg ? trig_o : hold) !== v) && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 100)
        begin
            n_mismatch++;
            $display("Error at %0t: wait ran out", $time);
            end_of_test();
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic pulse();
        trig <= 1'b1;
        repeat (4) @(posedge clk);
        trig <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // ==========================================
    // scenarios
    task automatic s_reset();
        check({13'h0000, int_n, req, trig_oe_n}, 16'h0005);
        check(oe_n, 16'hffff);
        rd(5'h10, 16'hffff, 16'h0000, 16'h0000);
    endtask
    task automatic s_rw16();
        wr(5'h12, 16'h0201);
        rd(5'h12, 16'hffff, 16'h0201, 16'h0000);
        wr(5'h12, 16'h00ff, 1'b0);
        rd(5'h12, 16'hffff, 16'h0201, 16'h0000, 1'b1);
        rd(5'h16, 16'hffff, 16'h0000, 16'h0000);
    endtask
    task automatic s_bw8();
        bw <= 1'b1;
        @(posedge clk);
        wr(5'h12, 16'haa05);
        rd(5'h12, 16'h00ff, 16'h0005, 16'hff00);
        rd(5'h13, 16'h00ff, 16'h0002, 16'hff00);
        bw <= 1'b0;
        @(posedge clk);
        rd(5'h12, 16'hffff, 16'h0205, 16'h0000);
    endtask
    task automatic s_instr();
        wr(5'h00, 16'h0055);
        check({9'h000, diff, neg, pos}, 16'h0055);
    endtask
    task automatic s_trig();
        conv <= 16'h1234;
        pulse();
        check(16'(hold), 16'h0001);
        wait_on(1'b0, 1'b0);
        check(16'(int_n), 16'h0000);
        rd(5'h14, 16'h3f0f, 16'h0109, 16'h0000);
        check(16'(int_n), 16'h0001);
        rd(5'h14, 16'h3fff, 16'h0100, 16'h0000);
        conv <= 16'h5678;
        pulse();
        wait_on(1'b0, 1'b0);
        check(16'(req), 16'h0001);
        rd(5'h1e, 16'hffff, 16'h1234, 16'h0000);
        check(16'(req), 16'h0001);
        rd(5'h1e, 16'hffff, 16'h5678, 16'h0000);
        check(16'(req), 16'h0000);
    endtask
    task automatic s_freeze();
        conv <= 16'h0abc;
        pulse();
        i_host.hold_select(80);
        check(16'(hold), 16'h0001);
        wait_on(1'b0, 1'b0);
        rd(5'h1e, 16'hffff, 16'h0abc, 16'h0000);
        conv <= 16'h0def;
        pulse();
        wait_on(1'b0, 1'b0);
        bw <= 1'b1;
        @(posedge clk);
        rd(5'h1e, 16'h00ff, 16'h00ef, 16'hff00);
        rd(5'h1f, 16'h00ff, 16'h000d, 16'hff00);
        bw <= 1'b0;
        @(posedge clk);
        rd(5'h14, 16'h3f00, 16'h0000, 16'h0000);
        check(16'(req), 16'h0000);
    endtask
    task automatic s_trig_out();
        wr(5'h10, 16'h0081);
        check(16'(trig_oe_n), 16'h0000);
        wait_on(1'b1, 1'b1);
        check(16'(hold), 16'h0001);
        wait_on(1'b1, 1'b0);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check(16'(trig_oe_n), 16'h0001);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(5'h10, 16'hffff, 16'h0000, 16'h0000);
    endtask
    // ==========================================
    // clock and main sequence
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        arst_n = 1'b0;
        bw = 1'b0;
        trig = 1'b0;
        conv = 16'h0000;
        n_mismatch = 0;
        check_count = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        s_reset();
        s_rw16();
        s_bw8();
        s_instr();
        s_trig();
        s_freeze();
        s_trig_out();
        end_of_test();
    end
endmodule
`default_nettype wire
